// >>> tb_usb_power_state_signalling.sv
// Self-checking bench for the power state signalling block
`timescale 1ns/100ps
`include "ups_consts.svh"
module tb_usb_power_state_signalling;
  typedef struct packed {
    logic [1:0] res;
    logic [1:0] code;
    logic       pu;
  } ups_tb_row_t;
  logic        ref_clk, rstn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, vbus, wake_in, tx_pend, rx_ev, tx_ev;
  logic        attach, rx_req, tx_req, b0, b1, pu, susp, pwr_n, rwake;
  logic        txen, rxl_n, txl_n, i0, i1, i2, irq, rerr, cen;
  logic [2:0]  btn;
  int          wake_cnt, rx_low, tx_low, tick, num_errors, num_checks;
  ups_tb_row_t rows [3];

  ups_top #(.LED_CYC(4)) ups_top_i (.ref_clk(ref_clk), .rstn(rstn),
    .clk_en(cen), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vbus_sense_input(vbus), .wake_in(wake_in),
    .uart_tx_pending(tx_pend), .usb_rx_event(rx_ev), .usb_tx_event(tx_ev),
    .button_pressed(btn), .charger_type_bit0(b0), .charger_type_bit1(b1),
    .dplus_pullup_en(pu), .suspend_out(susp), .power_n(pwr_n),
    .remote_wake(rwake), .line_driver_tx_enable(txen),
    .rx_activity_led_n(rxl_n), .tx_activity_led_n(txl_n),
    .button_index_0(i0), .button_index_1(i1), .button_index_2(i2), .irq(irq));
  ups_host_model ups_host_model_i (.ref_clk(ref_clk), .rstn(rstn),
    .attach(attach), .rx_req(rx_req), .tx_req(tx_req),
    .dplus_pullup_en(pu), .remote_wake(rwake), .vbus_sense_input(vbus),
    .usb_rx_event(rx_ev), .usb_tx_event(tx_ev), .wake_cnt(wake_cnt));

  // Free-running clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // LED low-time counters and the hang guard
  always @(posedge ref_clk) begin
    rx_low <= rx_low + (rxl_n === 1'b0);
    tx_low <= tx_low + (txl_n === 1'b0);
    tick <= tick + 1;
    if (tick == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 2, "wait states");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] x, input string s);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk(rdat & m, x, s);
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  localparam logic [31:0] DONE = 32'h1 << `UPS_CTRL_DONE;
  localparam logic [31:0] ENUM = 32'h1 << `UPS_CTRL_ENUM;
  localparam logic [31:0] SUSP = 32'h1 << `UPS_CTRL_SUSP;
  // Main sequence: reset, charger table, then hand-written cases
  initial begin
    {rstn, psel, penable, pwrite, wake_in, tx_pend, attach} = '0;
    cen = 1'b1;
    {rx_req, tx_req, paddr, pwdata, btn} = '0;
    {rx_low, tx_low, tick, num_errors, num_checks} = '0;
    rows[0] = '{`UPS_RES_SDP, `UPS_CHG_SDP, 1'b1};
    rows[1] = '{`UPS_RES_CDP, `UPS_CHG_CDP_DCP, 1'b1};
    rows[2] = '{`UPS_RES_DCP, `UPS_CHG_CDP_DCP, 1'b0};
    wcyc(2);
    chk({b1, b0, pu, susp, pwr_n, txen, rxl_n, txl_n, irq}, 9'h036, "rst");
    rstn <= 1'b1;
    rdchk(`UPS_OFF_CTRL, 32'hffffffff, `UPS_CTRL_RESET, "ctrl rst");
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      attach <= 1'b1;
      wcyc(6);
      wr(`UPS_OFF_CHG_RES, {30'h0, rows[i].res});
      wr(`UPS_OFF_CTRL, DONE);
      wcyc(4);
      chk({b1, b0}, rows[i].code, "code");
      chk(pu, rows[i].pu, "pullup");
      attach <= 1'b0;
      wcyc(8);
      chk({b1, b0, pu}, {`UPS_CHG_NONE, 1'b0}, "detach");
      wr(`UPS_OFF_CTRL, 32'h0);
    end
    $display("charger table done");
    // Attached as SDP for the remaining cases
    attach <= 1'b1;
    wcyc(6);
    wr(`UPS_OFF_CHG_RES, {30'h0, `UPS_RES_SDP});
    wr(`UPS_OFF_CTRL, DONE);
    wcyc(4);
    chk({susp, pwr_n}, 2'b11, "not enumerated");
    wr(`UPS_OFF_CTRL, DONE | ENUM | (32'h1 << `UPS_CTRL_LED_CFG));
    wcyc(3);
    chk({susp, pwr_n}, 2'b00, "configured");
    {rx_low, tx_low} = '0;
    rx_req <= 1'b1;
    wcyc(1);
    rx_req <= 1'b0;
    wcyc(10);
    chk({rx_low >= 4 && rx_low <= 5, tx_low == 0}, 2'b11, "rx led");
    tx_req <= 1'b1;
    wcyc(1);
    tx_req <= 1'b0;
    wcyc(10);
    chk(tx_low >= 4 && tx_low <= 5, 1, "tx led");
    wr(`UPS_OFF_CTRL, DONE | ENUM | SUSP);
    wcyc(3);
    chk({susp, pwr_n, b1, b0}, 4'hf, "suspended");
    wake_in <= 1'b1;
    wcyc(8);
    wake_in <= 1'b0;
    chk(wake_cnt, 1, "remote wake");
    rdchk(`UPS_OFF_CTRL, SUSP, 32'h0, "resume");
    chk(susp, 1'b0, "resumed");
    $display("suspend and led test done");
    // Interrupt: pending vbus-on event, masked, unmasked, cleared
    rdchk(`UPS_OFF_IRQ_STAT, 32'h1, 32'h1, "vbus on stat");
    chk(irq, 1'b0, "masked irq");
    wr(`UPS_OFF_IRQ_MASK, 32'h1);
    wcyc(3);
    chk(irq, 1'b1, "irq on");
    wr(`UPS_OFF_IRQ_STAT, 32'h1);
    wcyc(3);
    chk(irq, 1'b0, "irq cleared");
    rdchk(`UPS_OFF_IRQ_STAT, 32'h1, 32'h0, "stat cleared");
    apb(1'b0, 12'h018, 32'h0, rdat, rerr);
    chk(rerr, 1'b1, "unmapped err");
    chk(rdat, 32'h0, "unmapped data");
    rdchk(`UPS_OFF_ACTIVITY, 32'hffffffff, 32'h0, "zero word");
    $display("irq and bus test done");
    // Line driver enable only when configured
    tx_pend <= 1'b1;
    wcyc(3);
    chk(txen, 1'b0, "txen off cfg");
    wr(`UPS_OFF_CTRL, 32'h1 << `UPS_CTRL_TXEN_CFG);
    wcyc(3);
    chk(txen, 1'b1, "txen on");
    tx_pend <= 1'b0;
    wcyc(3);
    chk(txen, 1'b0, "txen idle");
    // Clock enable low must freeze the output despite a pending character
    cen <= 1'b0;
    tx_pend <= 1'b1;
    wcyc(3);
    chk(txen, 1'b0, "txen frozen");
    cen <= 1'b1;
    wcyc(3);
    chk(txen, 1'b1, "txen thawed");
    tx_pend <= 1'b0;
    // Button index in four- and two-button modes
    for (int m = 0; m < 2; m++) begin
      wr(`UPS_OFF_CTRL, m ? 32'h1 << `UPS_CTRL_BTN4 : 32'h0);
      for (int b = 0; b < 8; b++) begin
        btn <= 3'(b);
        wcyc(3);
        chk({i2, i1, i0}, m ? 3'(b) : {1'b0, 2'(b)}, "index");
      end
    end
    $display("txen and button test done");
    // Mid-run reset returns outputs and control to idle values
    rstn <= 1'b0;
    wcyc(2);
    chk({b1, b0, pu, susp, pwr_n, txen, rxl_n, txl_n, irq}, 9'h036, "rst2");
    rstn <= 1'b1;
    rdchk(`UPS_OFF_CTRL, 32'hffffffff, `UPS_CTRL_RESET, "ctrl rst2");
    $display("mid-run reset test done");
    test_done();
  end
endmodule // tb_usb_power_state_signalling

// >>> ups_consts.svh
// Constants for the USB power and status signalling block
`ifndef UPS_CONSTS_SVH
`define UPS_CONSTS_SVH
// Register byte offsets
`define UPS_OFF_CTRL      12'h000
`define UPS_OFF_STATUS    12'h004
`define UPS_OFF_IRQ_STAT  12'h008
`define UPS_OFF_IRQ_MASK  12'h00c
`define UPS_OFF_CHG_RES   12'h010
`define UPS_OFF_ACTIVITY  12'h014
// Control register fields
`define UPS_CTRL_TXEN_CFG 0
`define UPS_CTRL_LED_CFG  1
`define UPS_CTRL_BTN4     2
`define UPS_CTRL_ENUM     3
`define UPS_CTRL_SUSP     4
`define UPS_CTRL_DONE     5
`define UPS_CTRL_RESET    32'h0000_0000
// Charger indication codes
`define UPS_CHG_NONE      2'h0
`define UPS_CHG_SDP       2'h1
`define UPS_CHG_CDP_DCP   2'h2
`define UPS_CHG_SUSP      2'h3
// Charger result written by detection logic: 0 SDP, 1 CDP, 2 DCP
`define UPS_RES_SDP       2'h0
`define UPS_RES_CDP       2'h1
`define UPS_RES_DCP       2'h2
// Interrupt bits
`define UPS_IRQ_VBUS_ON   0
`define UPS_IRQ_VBUS_OFF  1
`define UPS_IRQ_DET_DONE  2
`define UPS_IRQ_WAKE      3
`define UPS_IRQ_W         4
// Timing: LED pulse length
`define UPS_LED_PULSE_NS  1000
`define UPS_CLK_NS        10
`define UPS_LED_CYC       ((`UPS_LED_PULSE_NS + `UPS_CLK_NS - 1) / `UPS_CLK_NS)
`endif

// >>> ups_host_model.sv
// Host or charger port model facing the power signalling block
`timescale 1ns/100ps
module ups_host_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic attach,
  input  wire logic rx_req,
  input  wire logic tx_req,
  input  wire logic dplus_pullup_en,
  input  wire logic remote_wake,
  output logic      vbus_sense_input,
  output logic      usb_rx_event,
  output logic      usb_tx_event,
  output int        wake_cnt
);
  // Host talks only once the device shows its pull-up
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vbus_sense_input <= 1'b0;
      usb_rx_event     <= 1'b0;
      usb_tx_event     <= 1'b0;
      wake_cnt         <= 0;
    end else begin
      vbus_sense_input <= attach;
      usb_rx_event     <= rx_req & dplus_pullup_en;
      usb_tx_event     <= tx_req & dplus_pullup_en;
      if (remote_wake) begin
        wake_cnt <= wake_cnt + 1;
      end
    end
  end
endmodule // ups_host_model

// >>> ups_pkg.sv
// Types for the USB power and status signalling block
package ups_pkg;
  typedef enum logic [3:0] {
    UPS_IDLE   = 4'b0001,
    UPS_DETECT = 4'b0010,
    UPS_READY  = 4'b0100,
    UPS_WAKE   = 4'b1000
  } ups_state_t;

  typedef struct packed {
    logic [1:0] chg_code;
    logic       pullup_en;
    logic       suspend_ind;
    logic       power_n;
    logic       remote_wake;
  } ups_pwr_t;

  typedef struct packed {
    logic       txd_en;
    logic       rx_led_n;
    logic       tx_led_n;
    logic [2:0] btn_idx;
  } ups_io_t;

  typedef struct packed {
    ups_state_t  st;
    logic [1:0]  vbus_sync;
    logic [1:0]  wake_sync;
    logic        vbus_prev;
    logic [31:0] ctrl;
    logic [1:0]  chg_res;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic [7:0]  rx_cnt;
    logic [7:0]  tx_cnt;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ups_pwr_t    pwr;
    ups_io_t     io;
  } ups_state_all_t;
endpackage

// >>> ups_top.sv
// USB power state, charger, suspend and board signalling block
`timescale 1ns/100ps
`include "ups_consts.svh"

//
// Behaviour
// - VBUS arriving starts charger detection, then shows type on charger pins.
// - SDP or CDP result enables the D+ pull-up for enumeration.
// - VBUS loss drives no-charger code and drops the D+ pull-up.
// - Suspend output high while link suspended or not yet enumerated.
// - Wake input during suspend causes resume and a remote wakeup request.
// - When configured, tx enable follows UART transmit buffer holding data.
// - Configured LED pins pulse low on USB receive and transmit traffic.
// - Four-button mode drives three index pins with pressed button code.
// - Two-button mode uses only two index pins.
// - Bus-detect input serves as VBUS present for charger detection.
// - Charger codes 00 none, 01 SDP, 10 CDP/DCP, 11 suspended.
// - Power-control low only while configured; high unconfigured or suspended.
module ups_top
  import ups_pkg::*;
#(
  parameter int LED_CYC = `UPS_LED_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        vbus_sense_input,
  input  wire logic        wake_in,
  input  wire logic        uart_tx_pending,
  input  wire logic        usb_rx_event,
  input  wire logic        usb_tx_event,
  input  wire logic [2:0]  button_pressed,
  output logic             charger_type_bit0,
  output logic             charger_type_bit1,
  output logic             dplus_pullup_en,
  output logic             suspend_out,
  output logic             power_n,
  output logic             remote_wake,
  output logic             line_driver_tx_enable,
  output logic             rx_activity_led_n,
  output logic             tx_activity_led_n,
  output logic             button_index_0,
  output logic             button_index_1,
  output logic             button_index_2,
  output logic             irq
);

  ups_state_all_t s;
  ups_state_all_t next_s;

  // Word decode shared by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  // Charger code for a detection result
  function automatic logic [1:0] res_code(input logic [1:0] r);
    return (r == `UPS_RES_SDP) ? `UPS_CHG_SDP : `UPS_CHG_CDP_DCP;
  endfunction

  logic vbus_s;
  logic wake_s;
  logic suspended;
  logic wr;
  logic rd;
  logic [4:0] ev;
  logic [31:0] rdata;

  assign vbus_s    = s.vbus_sync[1];
  assign wake_s    = s.wake_sync[1];
  assign suspended = s.ctrl[`UPS_CTRL_SUSP];
  // Write lands only on the completing edge, where pready is seen high
  assign wr = psel & penable & pwrite & s.pready;
  assign rd = psel & ~penable & ~pwrite;

  // Read mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit(paddr, `UPS_OFF_CTRL)) begin
      rdata = s.ctrl;
    end else if (hit(paddr, `UPS_OFF_STATUS)) begin
      rdata = {22'h0, s.st, s.pwr};
    end else if (hit(paddr, `UPS_OFF_IRQ_STAT)) begin
      rdata = {27'h0, s.irq_stat};
    end else if (hit(paddr, `UPS_OFF_IRQ_MASK)) begin
      rdata = {27'h0, s.irq_mask};
    end else if (hit(paddr, `UPS_OFF_CHG_RES)) begin
      rdata = {30'h0, s.chg_res};
    end
  end

  // All next-state logic in one process
  always_comb begin
    next_s = s;
    ev     = 5'h00;
    // Two-stage synchronisers, first stage read only by second
    next_s.vbus_sync = {s.vbus_sync[0], vbus_sense_input};
    next_s.wake_sync = {s.wake_sync[0], wake_in};
    next_s.vbus_prev = vbus_s;

    // APB: one wait state, answer in access phase
    next_s.pready  = psel & penable & ~s.pready;
    next_s.pslverr = 1'b0;
    if (rd) begin
      next_s.prdata = rdata;
    end
    if (psel & penable & ~s.pready) begin
      next_s.pslverr = ~(hit(paddr, `UPS_OFF_CTRL) |
                         hit(paddr, `UPS_OFF_STATUS) |
                         hit(paddr, `UPS_OFF_IRQ_STAT) |
                         hit(paddr, `UPS_OFF_IRQ_MASK) |
                         hit(paddr, `UPS_OFF_CHG_RES) |
                         hit(paddr, `UPS_OFF_ACTIVITY));
    end
    if (wr && hit(paddr, `UPS_OFF_CTRL)) begin
      next_s.ctrl = pwdata;
    end
    if (wr && hit(paddr, `UPS_OFF_IRQ_MASK)) begin
      next_s.irq_mask = pwdata[4:0];
    end
    if (wr && hit(paddr, `UPS_OFF_CHG_RES)) begin
      next_s.chg_res = pwdata[1:0];
    end

    // Power state machine
    case (s.st)
      UPS_IDLE: begin
        if (vbus_s) begin
          next_s.st = UPS_DETECT;
          ev[`UPS_IRQ_VBUS_ON] = 1'b1;
        end
      end
      UPS_DETECT: begin
        // Detection engine reports through the done control bit
        if (!vbus_s) begin
          next_s.st = UPS_IDLE;
        end else if (s.ctrl[`UPS_CTRL_DONE]) begin
          next_s.st = UPS_READY;
          ev[`UPS_IRQ_DET_DONE] = 1'b1;
        end
      end
      UPS_READY: begin
        if (!vbus_s) begin
          next_s.st = UPS_IDLE;
        end else if (suspended && wake_s) begin
          next_s.st = UPS_WAKE;
          ev[`UPS_IRQ_WAKE] = 1'b1;
        end
      end
      UPS_WAKE: begin
        // Resume clears suspend; wakeup request held one cycle
        next_s.ctrl[`UPS_CTRL_SUSP] = 1'b0;
        next_s.st = vbus_s ? UPS_READY : UPS_IDLE;
      end
      default: next_s.st = UPS_IDLE;
    endcase
    if (s.vbus_prev && !vbus_s) begin
      ev[`UPS_IRQ_VBUS_OFF] = 1'b1;
      next_s.ctrl[`UPS_CTRL_DONE] = 1'b0;
      next_s.ctrl[`UPS_CTRL_ENUM] = 1'b0;
    end

    // Power outputs
    next_s.pwr.remote_wake = (s.st == UPS_WAKE);
    if (!vbus_s || s.st == UPS_IDLE || s.st == UPS_DETECT) begin
      next_s.pwr.chg_code  = `UPS_CHG_NONE;
      next_s.pwr.pullup_en = 1'b0;
    end else begin
      next_s.pwr.chg_code = suspended ? `UPS_CHG_SUSP
                                      : res_code(s.chg_res);
      next_s.pwr.pullup_en = (s.chg_res != `UPS_RES_DCP);
    end
    next_s.pwr.suspend_ind = suspended | ~s.ctrl[`UPS_CTRL_ENUM];
    next_s.pwr.power_n = ~(s.ctrl[`UPS_CTRL_ENUM] & ~suspended);

    // Transmit enable for half-duplex driver
    next_s.io.txd_en = s.ctrl[`UPS_CTRL_TXEN_CFG] & uart_tx_pending;

    // LED stretchers, so short bursts stay visible
    if (usb_rx_event) begin
      next_s.rx_cnt = 8'(LED_CYC);
    end else if (s.rx_cnt != 8'h00) begin
      next_s.rx_cnt = s.rx_cnt - 8'h01;
    end
    if (usb_tx_event) begin
      next_s.tx_cnt = 8'(LED_CYC);
    end else if (s.tx_cnt != 8'h00) begin
      next_s.tx_cnt = s.tx_cnt - 8'h01;
    end
    next_s.io.rx_led_n = ~(s.ctrl[`UPS_CTRL_LED_CFG] &
                           (s.rx_cnt != 8'h00));
    next_s.io.tx_led_n = ~(s.ctrl[`UPS_CTRL_LED_CFG] &
                           (s.tx_cnt != 8'h00));

    // Button index: two-button mode drops the top pin
    if (s.ctrl[`UPS_CTRL_BTN4]) begin
      next_s.io.btn_idx = button_pressed;
    end else begin
      next_s.io.btn_idx = {1'b0, button_pressed[1:0]};
    end

    // Sticky events: set wins over write-one-to-clear
    if (wr && hit(paddr, `UPS_OFF_IRQ_STAT)) begin
      next_s.irq_stat = s.irq_stat & ~pwdata[4:0];
    end
    next_s.irq_stat = next_s.irq_stat | ev;
    next_s.irq = |(s.irq_stat & s.irq_mask);
  end

  // State register with clock enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: UPS_IDLE, ctrl: `UPS_CTRL_RESET,
             pwr: '{chg_code: `UPS_CHG_NONE, pullup_en: 1'b0,
                    suspend_ind: 1'b1, power_n: 1'b1, remote_wake: 1'b0},
             io: '{txd_en: 1'b0, rx_led_n: 1'b1, tx_led_n: 1'b1,
                   btn_idx: 3'h0},
             default: '0};
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign prdata                = s.prdata;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign charger_type_bit0     = s.pwr.chg_code[0];
  assign charger_type_bit1     = s.pwr.chg_code[1];
  assign dplus_pullup_en       = s.pwr.pullup_en;
  assign suspend_out           = s.pwr.suspend_ind;
  assign power_n               = s.pwr.power_n;
  assign remote_wake           = s.pwr.remote_wake;
  assign line_driver_tx_enable = s.io.txd_en;
  assign rx_activity_led_n     = s.io.rx_led_n;
  assign tx_activity_led_n     = s.io.tx_led_n;
  assign button_index_0        = s.io.btn_idx[0];
  assign button_index_1        = s.io.btn_idx[1];
  assign button_index_2        = s.io.btn_idx[2];
  assign irq                   = s.irq;

  // Checks
  sequence s_vbus_lost;
    s.vbus_prev && !vbus_s;
  endsequence
  property p_det_start;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && s.st == UPS_IDLE && vbus_s |=> s.st == UPS_DETECT;
  endproperty
  a_det_start: assert property (p_det_start)
    else $error("detection did not start");
  property p_pullup;
    @(posedge ref_clk) disable iff (!rstn)
      dplus_pullup_en |-> $past(s.chg_res) != `UPS_RES_DCP;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up on for dedicated charger");
  property p_vbus_off;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && !vbus_s |=> !dplus_pullup_en && charger_type_bit0 == 1'b0
                            && charger_type_bit1 == 1'b0;
  endproperty
  a_vbus_off: assert property (p_vbus_off)
    else $error("pull-up or code kept without vbus");
  property p_susp;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && !s.ctrl[`UPS_CTRL_ENUM] |=> suspend_out;
  endproperty
  a_susp: assert property (p_susp)
    else $error("suspend low while not enumerated");
  property p_wake;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && s.st == UPS_READY && vbus_s && suspended && wake_s
      ##1 clk_en |=> remote_wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no remote wakeup");
  property p_txen;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en |=> line_driver_tx_enable ==
                 ($past(s.ctrl[`UPS_CTRL_TXEN_CFG]) && $past(uart_tx_pending));
  endproperty
  a_txen: assert property (p_txen)
    else $error("tx enable mismatch");
  property p_led;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && s.ctrl[`UPS_CTRL_LED_CFG] && usb_rx_event
      ##1 clk_en |=> !rx_activity_led_n;
  endproperty
  a_led: assert property (p_led)
    else $error("rx led did not pulse");
  property p_btn2;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && !s.ctrl[`UPS_CTRL_BTN4] |=> !button_index_2;
  endproperty
  a_btn2: assert property (p_btn2)
    else $error("third index pin used in two-button mode");
  property p_power;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && suspended |=> power_n;
  endproperty
  a_power: assert property (p_power)
    else $error("power enabled during suspend");
  property p_vbus_event;
    @(posedge ref_clk) disable iff (!rstn)
      (clk_en and s_vbus_lost) |=> s.irq_stat[`UPS_IRQ_VBUS_OFF];
  endproperty
  a_vbus_event: assert property (p_vbus_event)
    else $error("vbus loss not flagged");

endmodule // ups_top
